// [common/tpg_pkg.sv]
// Purpose: Shared constants for the transmit test pattern generator.
// Assumes: Eight-bit parallel control port with a four-bit address.
// Notes: Register offsets, field positions, reset values and step helpers.

package tpg_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_POLY_LENGTH = 4'h1;
  localparam logic [3:0] ADDR_PATTERN_LENGTH_LOW = 4'h2;
  localparam logic [3:0] ADDR_PATTERN_LENGTH_HIGH = 4'h3;
  localparam logic [3:0] ADDR_TAP_BASE = 4'h4;
  localparam logic [3:0] ADDR_SEED_BASE = 4'h8;
  localparam logic [3:0] ADDR_RAM_ADDR_LOW = 4'hc;
  localparam logic [3:0] ADDR_RAM_ADDR_HIGH = 4'hd;
  localparam logic [3:0] ADDR_RAM_DATA = 4'he;
  localparam logic [3:0] ADDR_GEN_STATE = 4'hf;

  // ==========================================================
  // Control register fields
  localparam int CTRL_SEED_LOAD_BIT = 0;
  localparam int CTRL_QUASI_LIMIT_BIT = 1;
  localparam int CTRL_MSB_FIRST_BIT = 2;
  localparam int CTRL_REPEAT_BIT = 3;
  localparam int CTRL_WIDTH_LSB = 4;
  localparam logic [1:0] WIDTH_SERIAL = 2'h0;
  localparam logic [1:0] WIDTH_NIBBLE = 2'h1;

  // ==========================================================
  // Sizes and reset values
  localparam int POLY_W = 32;
  localparam int RAM_DEPTH = 512;
  localparam int RAM_ADDR_W = 9;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [2:0] BYTE_MSB = 3'h7;
  localparam logic [2:0] BIT_IDX_FIRST = 3'h0;
  localparam logic [3:0] ZERO_RUN_LIMIT = 4'he;
  localparam logic [3:0] ZERO_RUN_CLEAR = 4'h0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [4:0] POLY_LENGTH_RESET = 5'h00;
  localparam logic [8:0] PATTERN_LENGTH_RESET = 9'h000;
  localparam logic [31:0] TAP_RESET = 32'h0000_0000;
  localparam logic [31:0] SEED_RESET = 32'h0000_0001;
  localparam logic [31:0] LFSR_RESET = 32'h0000_0001;
  localparam logic [8:0] RAM_ADDR_RESET = 9'h000;
  localparam logic [8:0] RAM_ADDR_FIRST = 9'h000;
  localparam logic [8:0] RAM_ADDR_STEP = 9'h001;
  localparam logic [7:0] BYTE_CLEAR = 8'h00;

  // Mask of the active stages; field holds stage count minus one
  function automatic logic [31:0] stage_mask(input logic [4:0] len_m1);
    stage_mask = 32'hffff_ffff >> (5'h1f - len_m1);
  endfunction

  // Bits sent per transmit clock for a width code
  function automatic logic [3:0] bits_per_step(input logic [1:0] width);
    unique case (width)
      WIDTH_SERIAL: bits_per_step = 4'h1;
      WIDTH_NIBBLE: bits_per_step = 4'h4;
      default: bits_per_step = 4'h8;
    endcase
  endfunction

endpackage

// [hw/pattern_store.sv]
// Purpose: Pattern byte store with one write port and two read ports.
// Assumes: Reads are combinational; writes land on the clock edge.
// Notes: Contents are not reset; software must load them before use.

`timescale 1ns/1ps
`default_nettype none

module pattern_store (
  input wire logic clk_sys,
  input wire logic write_en,
  input wire logic [tpg_pkg::RAM_ADDR_W-1:0] write_addr,
  input wire logic [7:0] write_data,
  input wire logic [tpg_pkg::RAM_ADDR_W-1:0] cpu_addr,
  output logic [7:0] cpu_data,
  input wire logic [tpg_pkg::RAM_ADDR_W-1:0] tx_addr,
  output logic [7:0] tx_data
);

  logic [7:0] mem [tpg_pkg::RAM_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (write_en) begin
      mem[write_addr] <= write_data;
    end
  end

  assign cpu_data = mem[cpu_addr];
  assign tx_data = mem[tx_addr];

endmodule

`default_nettype wire

// [hw/test_pattern_generator.sv]
// Purpose: Transmit-side test pattern generator, pseudorandom or repetitive.
// Assumes: Control port and transmit pins are synchronous to clk_sys.
// Notes: One pattern step per rising tx_clock edge seen while qualified and not in the same cycle as a seed load.
//
// Functional notes
// - A 32-bit tap mask selects which generator stages feed back.
// - A 0-to-1 write of the seed load strobe copies the seed into the generator.
// - Generator length (1 to 32 stages) and taps are both programmable.
// - With the quasi-random limit set, a bit is forced to 1 to end a 14-zero run.
// - 512 pattern bytes are reached only through an indirect address and data port.
// - A nine-bit pattern length split over offsets 02h and 03h bounds the replay.
// - Pattern bytes are sent most or least significant bit first as programmed.
// - Repetitive patterns are replayed in whole bytes only.
// - With the qualifier low the transmit pins hold the last value sent, one to eight bits by width.

`timescale 1ns/1ps
`default_nettype none

module test_pattern_generator (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic tx_clock,
  input wire logic transmit_clock_qualifier,
  output logic [7:0] transmit_data_out
);

  // ==========================================================
  // Control port state
  logic [7:0] control_q, control_d;
  logic [4:0] poly_len_q, poly_len_d;
  logic [8:0] pat_len_q, pat_len_d;
  logic [31:0] tap_q, tap_d;
  logic [31:0] seed_q, seed_d;
  logic [8:0] ram_addr_q, ram_addr_d;
  logic wr_q, rd_q;
  logic [7:0] rd_data_q, rd_data_d;
  logic oe_q, oe_d;
  logic wr_go, rd_go, ram_we, seed_load;
  logic [7:0] ram_cpu_data, ram_tx_data;

  // ==========================================================
  // Transmit state
  logic tclk_q;
  logic [31:0] lfsr_q, lfsr_d;
  logic [3:0] zrun_q, zrun_d;
  logic [2:0] bit_idx_q, bit_idx_d;
  logic [8:0] rptr_q, rptr_d;
  logic [7:0] tx_q, tx_d;
  logic step, repeat_mode, msb_first, byte_done, fb, bit_val;
  logic [3:0] step_bits;
  logic [31:0] len_mask;
  logic [7:0] word;

  assign wr_go = !chip_select_n && !write_n && !wr_q;
  assign rd_go = !chip_select_n && !read_n && !rd_q;
  // Only the data window touches the store; no direct byte addresses
  assign ram_we = wr_go && (address == tpg_pkg::ADDR_RAM_DATA);
  assign seed_load = wr_go && (address == tpg_pkg::ADDR_CONTROL)
    && data_in[tpg_pkg::CTRL_SEED_LOAD_BIT]
    && !control_q[tpg_pkg::CTRL_SEED_LOAD_BIT];

  pattern_store u_store (
    .clk_sys(clk_sys),
    .write_en(ram_we),
    .write_addr(ram_addr_q),
    .write_data(data_in),
    .cpu_addr(ram_addr_q),
    .cpu_data(ram_cpu_data),
    .tx_addr(rptr_q),
    .tx_data(ram_tx_data)
  );

  // ==========================================================
  // Register writes and reads
  always_comb begin
    control_d = control_q;
    poly_len_d = poly_len_q;
    pat_len_d = pat_len_q;
    tap_d = tap_q;
    seed_d = seed_q;
    ram_addr_d = ram_addr_q;
    rd_data_d = rd_data_q;
    oe_d = !chip_select_n && !read_n;
    if (wr_go) begin
      unique case (address)
        tpg_pkg::ADDR_CONTROL: control_d = data_in;
        tpg_pkg::ADDR_POLY_LENGTH: poly_len_d = data_in[4:0];
        tpg_pkg::ADDR_PATTERN_LENGTH_LOW: pat_len_d[7:0] = data_in;
        tpg_pkg::ADDR_PATTERN_LENGTH_HIGH: pat_len_d[8] = data_in[0];
        tpg_pkg::ADDR_RAM_ADDR_LOW: ram_addr_d[7:0] = data_in;
        tpg_pkg::ADDR_RAM_ADDR_HIGH: ram_addr_d[8] = data_in[0];
        tpg_pkg::ADDR_RAM_DATA: ram_addr_d = ram_addr_q + tpg_pkg::RAM_ADDR_STEP;
        tpg_pkg::ADDR_GEN_STATE: ;
        default: begin
          if (address < tpg_pkg::ADDR_SEED_BASE) begin
            tap_d[8*address[1:0] +: 8] = data_in;
          end else begin
            seed_d[8*address[1:0] +: 8] = data_in;
          end
        end
      endcase
    end
    if (rd_go) begin
      unique case (address)
        tpg_pkg::ADDR_CONTROL: rd_data_d = control_q;
        tpg_pkg::ADDR_POLY_LENGTH: rd_data_d = {3'h0, poly_len_q};
        tpg_pkg::ADDR_PATTERN_LENGTH_LOW: rd_data_d = pat_len_q[7:0];
        tpg_pkg::ADDR_PATTERN_LENGTH_HIGH: rd_data_d = {7'h00, pat_len_q[8]};
        tpg_pkg::ADDR_RAM_ADDR_LOW: rd_data_d = ram_addr_q[7:0];
        tpg_pkg::ADDR_RAM_ADDR_HIGH: rd_data_d = {7'h00, ram_addr_q[8]};
        tpg_pkg::ADDR_RAM_DATA: begin
          rd_data_d = ram_cpu_data;
          ram_addr_d = ram_addr_q + tpg_pkg::RAM_ADDR_STEP;
        end
        tpg_pkg::ADDR_GEN_STATE: rd_data_d = lfsr_q[7:0];
        default: begin
          if (address < tpg_pkg::ADDR_SEED_BASE) begin
            rd_data_d = tap_q[8*address[1:0] +: 8];
          end else begin
            rd_data_d = seed_q[8*address[1:0] +: 8];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      control_q <= tpg_pkg::CONTROL_RESET;
      poly_len_q <= tpg_pkg::POLY_LENGTH_RESET;
      pat_len_q <= tpg_pkg::PATTERN_LENGTH_RESET;
      tap_q <= tpg_pkg::TAP_RESET;
      seed_q <= tpg_pkg::SEED_RESET;
      ram_addr_q <= tpg_pkg::RAM_ADDR_RESET;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd_data_q <= tpg_pkg::BYTE_CLEAR;
      oe_q <= 1'b0;
    end else begin
      control_q <= control_d;
      poly_len_q <= poly_len_d;
      pat_len_q <= pat_len_d;
      tap_q <= tap_d;
      seed_q <= seed_d;
      ram_addr_q <= ram_addr_d;
      wr_q <= !chip_select_n && !write_n;
      rd_q <= !chip_select_n && !read_n;
      rd_data_q <= rd_data_d;
      oe_q <= oe_d;
    end
  end

  assign data_out = rd_data_q;
  assign data_oe = oe_q;

  // ==========================================================
  // Pattern engine
  assign step = tx_clock && !tclk_q && transmit_clock_qualifier;
  assign repeat_mode = control_q[tpg_pkg::CTRL_REPEAT_BIT];
  assign msb_first = control_q[tpg_pkg::CTRL_MSB_FIRST_BIT];
  assign step_bits = tpg_pkg::bits_per_step(control_q[tpg_pkg::CTRL_WIDTH_LSB +: 2]);
  assign len_mask = tpg_pkg::stage_mask(poly_len_q);

  // First bit of a step lands on the highest used pin, last on pin 0
  always_comb begin
    lfsr_d = lfsr_q;
    zrun_d = zrun_q;
    bit_idx_d = bit_idx_q;
    rptr_d = rptr_q;
    tx_d = tx_q;
    word = tpg_pkg::BYTE_CLEAR;
    byte_done = 1'b0;
    fb = 1'b0;
    bit_val = 1'b0;
    if (seed_load) begin
      lfsr_d = seed_q & len_mask;
      zrun_d = tpg_pkg::ZERO_RUN_CLEAR;
    end else if (step) begin
      for (int i = 0; i < tpg_pkg::BITS_PER_BYTE; i++) begin
        if (4'(i) < step_bits) begin
          if (repeat_mode) begin
            bit_val = msb_first ? ram_tx_data[tpg_pkg::BYTE_MSB - bit_idx_d]
                                : ram_tx_data[bit_idx_d];
            if (bit_idx_d == tpg_pkg::BYTE_MSB) begin
              byte_done = 1'b1;
            end
            bit_idx_d = bit_idx_d + 3'h1;
          end else begin
            fb = ^(lfsr_d & tap_q);
            lfsr_d = {lfsr_d[30:0], fb} & len_mask;
            bit_val = fb;
            // Run counter limits zeros instead of looking 14 bits ahead
            if (control_q[tpg_pkg::CTRL_QUASI_LIMIT_BIT] && !bit_val
                && zrun_d == tpg_pkg::ZERO_RUN_LIMIT) begin
              bit_val = 1'b1;
            end
            zrun_d = bit_val ? tpg_pkg::ZERO_RUN_CLEAR : zrun_d + 4'h1;
          end
          word = {word[6:0], bit_val};
        end
      end
      if (byte_done) begin
        // Greater-or-equal also recovers if the length shrinks mid-run
        rptr_d = (rptr_q >= pat_len_q) ? tpg_pkg::RAM_ADDR_FIRST
                                       : rptr_q + tpg_pkg::RAM_ADDR_STEP;
      end
      tx_d = word;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tclk_q <= 1'b0;
      lfsr_q <= tpg_pkg::LFSR_RESET;
      zrun_q <= tpg_pkg::ZERO_RUN_CLEAR;
      bit_idx_q <= tpg_pkg::BIT_IDX_FIRST;
      rptr_q <= tpg_pkg::RAM_ADDR_FIRST;
      tx_q <= tpg_pkg::BYTE_CLEAR;
    end else begin
      tclk_q <= tx_clock;
      lfsr_q <= lfsr_d;
      zrun_q <= zrun_d;
      bit_idx_q <= bit_idx_d;
      rptr_q <= rptr_d;
      tx_q <= tx_d;
    end
  end

  assign transmit_data_out = tx_q;

endmodule

`default_nettype wire

// [verif/tpg_asserts.sv]
// Purpose: Port timing checks for the test pattern generator.
// Assumes: Sees only the ports of test_pattern_generator.
// Notes: Read drive timing and transmit hold behaviour.
`timescale 1ns/1ps
`default_nettype none
module tpg_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic tx_clock,
  input wire logic transmit_clock_qualifier,
  input wire logic [7:0] transmit_data_out
);
  // ==========================================
  // Helpers
  logic rd_low;
  logic rd_q;
  logic clk_q;
  logic rd_take;
  logic step;
  logic gated;
  assign rd_low = !chip_select_n && !read_n;
  assign rd_take = rd_low && !rd_q;
  assign step = tx_clock && !clk_q && transmit_clock_qualifier;
  assign gated = tx_clock && !clk_q && !transmit_clock_qualifier;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_q <= 1'b0;
      clk_q <= 1'b0;
    end else begin
      rd_q <= rd_low;
      clk_q <= tx_clock;
    end
  end
  // ==========================================
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  rd_answer_a: assert property (rd_take |=> data_oe) else $error("no drive after read");
  oe_stand_a: assert property (rd_low [*2] |-> data_oe) else $error("drive dropped");
  oe_release_a: assert property (!rd_low |=> !data_oe) else $error("drive held");
  oe_cause_a: assert property (data_oe |-> $past(rd_low)) else $error("drive uncaused");
  rd_hold_a: assert property (!rd_take |=> $stable(data_out)) else $error("read data moved");
  tx_hold_a: assert property (!step |=> $stable(transmit_data_out)) else $error("tx moved");
  gate_hold_a: assert property (gated |=> $stable(transmit_data_out) [*2])
    else $error("gated tx moved");
  rst_clear_a: assert property ($fell(rst) |-> transmit_data_out == 8'h00 && !data_oe)
    else $error("outputs not clear");
  cover property (rd_take);
  cover property (step);
  cover property (gated);
endmodule
bind test_pattern_generator tpg_asserts chk_u (.clk_sys(clk_sys), .rst(rst),
  .chip_select_n(chip_select_n), .read_n(read_n), .data_out(data_out), .data_oe(data_oe),
  .tx_clock(tx_clock), .transmit_clock_qualifier(transmit_clock_qualifier),
  .transmit_data_out(transmit_data_out));
`default_nettype wire

// [verif/link_sink.sv]
// Purpose: Link under test: makes the transmit clock and records steps.
// Assumes: Clock runs only while run is high; gap gates every second rise.
// Notes: Recorded value is the output one edge after a qualified rise.
`timescale 1ns/1ps
`default_nettype none
module link_sink (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic gap,
  input wire logic [7:0] transmit_data_out,
  output logic tx_clock,
  output logic transmit_clock_qualifier
);
  logic [7:0] got [$];
  logic [2:0] ph;
  logic pend;
  logic prev;
  initial begin
    tx_clock = 1'b0;
    transmit_clock_qualifier = 1'b1;
    ph = 3'h0;
    pend = 1'b0;
    prev = 1'b0;
  end
  // Clock stands still outside runs; two cycles low between rises
  always @(negedge clk_sys) begin
    tx_clock <= run && ph[1];
    transmit_clock_qualifier <= !(gap && ph[2]);
    ph <= run ? ph + 3'h1 : 3'h0;
  end
  always @(posedge clk_sys) begin
    if (pend) begin
      got.push_back(transmit_data_out);
    end
    pend <= tx_clock && !prev && transmit_clock_qualifier && !rst;
    prev <= tx_clock;
  end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Purpose: Self-checking bench for the test pattern generator.
// Assumes: Inputs change on the falling clock edge.
// Notes: Each mode is run from a fresh reset; pattern RAM survives reset.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys, rst, chip_select_n, read_n, write_n, data_oe, tx_clock, qual, run, gap;
  logic [3:0] address;
  logic [7:0] data_in, data_out, transmit_data_out, v;
  logic [7:0] ram [0:7];
  logic [7:0] five [0:4] = '{8'h10, 8'h42, 8'h08, 8'h21, 8'h84};
  logic [31:0] st, tp, mk;
  logic fb;
  int seed, n_mismatch, n_tests, len, nb, n, k, i, j;
  test_pattern_generator dut_u (.clk_sys(clk_sys), .rst(rst), .address(address),
    .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .tx_clock(tx_clock),
    .transmit_clock_qualifier(qual), .transmit_data_out(transmit_data_out));
  link_sink sink_u (.clk_sys(clk_sys), .rst(rst), .run(run), .gap(gap),
    .transmit_data_out(transmit_data_out), .tx_clock(tx_clock),
    .transmit_clock_qualifier(qual));
  // ==========================================
  // Tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    address = a;
    data_in = d;
    chip_select_n = 1'b0;
    write_n = 1'b0;
    @(negedge clk_sys);
    chip_select_n = 1'b1;
    write_n = 1'b1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    address = a;
    chip_select_n = 1'b0;
    read_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    d = data_out;
    chip_select_n = 1'b1;
    read_n = 1'b1;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic reboot;
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    sink_u.got.delete();
  endtask
  task automatic collect(input int cnt);
    run <= 1'b1;
    k = 0;
    while (sink_u.got.size() < cnt && k < 20000) begin
      @(negedge clk_sys);
      k++;
    end
    run <= 1'b0;
    // A stalled link counts against the run
    if (sink_u.got.size() < cnt) begin
      n_mismatch++;
      $display("MISMATCH collect expected %0d seen %0d", cnt, sink_u.got.size());
    end
  endtask
  function automatic int bpw(input int w);
    return w == 0 ? 1 : (w == 1 ? 4 : 8);
  endfunction
  // First bit of a step lands on the highest used pin
  function automatic logic [7:0] rep_exp(input int s, input int w, input int m, input int b);
    logic [7:0] o;
    int p;
    o = 8'h00;
    for (int x = 0; x < bpw(w); x++) begin
      p = s * bpw(w) + x;
      o = {o[6:0], ram[(p / 8) % b][m ? 7 - p % 8 : p % 8]};
    end
    return o;
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {rst, chip_select_n, read_n, write_n, run, gap} = 6'b111100;
    address = 4'h0;
    data_in = 8'h00;
    seed = 32'h95bc;
    n_mismatch = 0;
    n_tests = 0;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    len = $random(seed) & 32'h1ff;
    wr(tpg_pkg::ADDR_PATTERN_LENGTH_LOW, len[7:0]);
    wr(tpg_pkg::ADDR_PATTERN_LENGTH_HIGH, {7'h00, len[8]});
    rd(tpg_pkg::ADDR_PATTERN_LENGTH_LOW, v);
    cmp("len_low", len[7:0], v);
    rd(tpg_pkg::ADDR_PATTERN_LENGTH_HIGH, v);
    cmp("len_high", {7'h00, len[8]}, v);
    for (i = 0; i < 8; i++) begin
      ram[i] = $random(seed);
      wr(tpg_pkg::ADDR_RAM_DATA, ram[i]);
    end
    wr(tpg_pkg::ADDR_RAM_ADDR_LOW, 8'h00);
    wr(tpg_pkg::ADDR_RAM_ADDR_HIGH, 8'h00);
    for (i = 0; i < 8; i++) begin
      rd(tpg_pkg::ADDR_RAM_DATA, v);
      cmp("ram", ram[i], v);
    end
    rd(tpg_pkg::ADDR_RAM_ADDR_LOW, v);
    cmp("ram_addr", 8'h08, v);
    $display("done registers");
    // Every width and bit order, qualifier gating every second rise
    gap = 1'b1;
    for (j = 0; j < 6; j++) begin
      reboot();
      nb = (j == 0) ? 1 : 1 + ($random(seed) & 7);
      wr(tpg_pkg::ADDR_PATTERN_LENGTH_LOW, 8'(nb - 1));
      wr(tpg_pkg::ADDR_CONTROL, 8'h08 | 8'((j % 2) << 2) | 8'((j / 2) << 4));
      n = 2 * nb * 8 / bpw(j / 2) + 1;
      collect(n);
      for (i = 0; i < n; i++) begin
        v = sink_u.got[i] & (8'hff >> (8 - bpw(j / 2)));
        cmp("repeat", rep_exp(i, j / 2, j % 2, nb), v);
      end
    end
    gap = 1'b0;
    $display("done repetitive");
    reboot();
    for (i = 0; i < 5; i++) begin
      wr(tpg_pkg::ADDR_RAM_DATA, five[i]);
    end
    wr(tpg_pkg::ADDR_PATTERN_LENGTH_LOW, 8'h04);
    // Table bytes give the five-bit run when sent least significant bit first
    wr(tpg_pkg::ADDR_CONTROL, 8'h08);
    collect(50);
    for (i = 0; i < 50; i++) begin
      cmp("five", {7'h00, i % 5 == 4}, {7'h00, sink_u.got[i][0]});
    end
    $display("done five bit");
    for (j = 0; j < 3; j++) begin
      reboot();
      len = (j == 0) ? 31 : ($random(seed) & 31);
      tp = $random(seed);
      st = $random(seed);
      wr(tpg_pkg::ADDR_POLY_LENGTH, len[7:0]);
      for (i = 0; i < 4; i++) begin
        wr(tpg_pkg::ADDR_TAP_BASE + 4'(i), tp[8 * i +: 8]);
        wr(tpg_pkg::ADDR_SEED_BASE + 4'(i), st[8 * i +: 8]);
      end
      wr(tpg_pkg::ADDR_CONTROL, 8'h01);
      mk = 32'hffff_ffff >> (31 - len);
      st = st & mk;
      rd(tpg_pkg::ADDR_GEN_STATE, v);
      cmp("state", st[7:0], v);
      rd(tpg_pkg::ADDR_TAP_BASE + 4'(j), v);
      cmp("tap", tp[8 * j +: 8], v);
      collect(40);
      for (i = 0; i < 40; i++) begin
        fb = ^(st & tp);
        st = {st[30:0], fb} & mk;
        cmp("prbs", {7'h00, fb}, {7'h00, sink_u.got[i][0]});
      end
    end
    $display("done pseudorandom");
    // Zero taps give a constant zero stream unless the limiter acts
    for (j = 0; j < 2; j++) begin
      reboot();
      wr(tpg_pkg::ADDR_CONTROL, j ? 8'h02 : 8'h00);
      collect(45);
      for (i = 0; i < 45; i++) begin
        cmp("limit", {7'h00, j == 1 && i % 15 == 14}, {7'h00, sink_u.got[i][0]});
      end
    end
    $display("done limiter");
    tally_and_finish();
  end
endmodule
`default_nettype wire
